// >>> logic/mem_model.sv
// Operation
// - Zero to five write and read ports
// - Data width 8, 16, 32, 64, 128 only
// - Address width 1-32, size plus offset fits
// - Fixed zero-to-ten wait states per write beat
// - Pipelined reads, latency 1 to 255
// - Capacity equals size parameter in bytes
// - Lowest responding address equals offset
// - Write stall while write cannot be taken
// - Read stall while read cannot be taken
// - Valid strobe marks each returned read word
// - Master raises write request with address, data
// - Master gives beat count with each write
// - Master raises read request with address
// - Master gives read beat count; words returned
`timescale 1ns/1ns
`include "mem_model_consts.svh"

module mem_model #(
   parameter int NUM_WR      = `NUM_WR_PORTS,
   parameter int NUM_RD      = `NUM_RD_PORTS,
   parameter int DATA_BITS   = `DATA_W,
   parameter int ADDR_BITS   = `ADDR_W,
   parameter int WAIT_STATES = `WAIT_STATES,
   parameter int LATENCY     = `READ_LATENCY,
   parameter int SIZE_BYTES  = `MEM_SIZE_BYTES,
   parameter int OFFSET      = `MEM_OFFSET
) (
   input  wire logic clock,
   input  wire logic rst_n,
   mem_link_if.model link,
   output logic      cfg_fault
);
   import mem_types_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Configuration check

   function automatic logic config_good();
      logic ok;
      ok = 1'b1;
      ok &= (NUM_WR >= 0) && (NUM_WR <= `MAX_PORTS) && (NUM_RD >= 0) && (NUM_RD <= `MAX_PORTS);
      ok &= (DATA_BITS == 8) || (DATA_BITS == 16) || (DATA_BITS == 32) || (DATA_BITS == 64)
            || (DATA_BITS == 128);
      ok &= (DATA_BITS == `DATA_W);
      ok &= (ADDR_BITS >= 1) && (ADDR_BITS <= `MAX_ADDR_W) && (ADDR_BITS == `ADDR_W);
      ok &= (64'(SIZE_BYTES) + 64'(OFFSET)) < (64'h1 << ADDR_BITS);
      ok &= (SIZE_BYTES >= 1) && (OFFSET >= 0);
      ok &= (WAIT_STATES >= 0) && (WAIT_STATES <= `MAX_WAIT);
      ok &= (LATENCY >= 1) && (LATENCY <= `MAX_LATENCY);
      return ok;
   endfunction : config_good

   localparam logic     CFG_OK = config_good();
   localparam int       BYTES  = (DATA_BITS >= 8) ? DATA_BITS / 8 : 1;
   localparam int       WORDS  = (SIZE_BYTES / BYTES > 0) ? SIZE_BYTES / BYTES : 1;
   localparam int       LAT    = (LATENCY >= 1 && LATENCY <= `MAX_LATENCY) ? LATENCY : 1;
   localparam logic [3:0] WAIT4 = 4'(WAIT_STATES);

   // byte address to word index, out of range below offset
   function automatic logic [31:0] word_index(input loc_t loc);
      logic signed [63:0] diff;
      // Signed, so a burst that starts below the offset only lands once it reaches it
      diff = signed'(64'(loc) - 64'(OFFSET));
      return 32'(diff >>> $clog2(BYTES));
   endfunction : word_index

   function automatic logic in_range(input logic [31:0] idx);
      return 64'(idx) < 64'(WORDS);
   endfunction : in_range

   function automatic beats_t first_left(input beats_t count);
      return (count > 8'h01) ? count - 8'h01 : 8'h00;
   endfunction : first_left

   word_t       mem         [WORDS];
   logic [3:0]  wr_wait     [`MAX_PORTS];
   beats_t      wr_left     [`MAX_PORTS];
   logic [31:0] wr_idx      [`MAX_PORTS];
   logic        wr_take     [`MAX_PORTS];
   logic [31:0] wr_cur      [`MAX_PORTS];
   beats_t      rd_left     [`MAX_PORTS];
   logic [31:0] rd_idx      [`MAX_PORTS];
   logic        rd_take     [`MAX_PORTS];
   logic        rd_issue    [`MAX_PORTS];
   logic [31:0] rd_cur      [`MAX_PORTS];
   logic        rd_ok_pipe  [`MAX_PORTS][`MAX_LATENCY];
   word_t       rd_dat_pipe [`MAX_PORTS][`MAX_LATENCY];

   always_ff @(posedge clock) begin : fault_flag
      cfg_fault <= !CFG_OK;
   end

   ////////////////////////////////////////////////////////////////////////
   // Beat decode shared by storage and control

   always_comb begin
      for (int p = 0; p < `MAX_PORTS; p++) begin
         wr_take[p]  = link.wr_port_request[p] && !link.wr_port_stall[p];
         // burst beats step by one word
         wr_cur[p]   = (wr_left[p] == 8'h00) ? word_index(link.wr_port_location[p]) : wr_idx[p];
         rd_take[p]  = link.rd_port_request[p] && !link.rd_port_stall[p];
         rd_issue[p] = rd_take[p] || (rd_left[p] != 8'h00);
         rd_cur[p]   = rd_take[p] ? word_index(link.rd_port_location[p]) : rd_idx[p];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write ports

   always_ff @(posedge clock) begin : write_ctrl
      for (int p = 0; p < `MAX_PORTS; p++) begin
         if (!rst_n || p >= NUM_WR || !CFG_OK) begin
            link.wr_port_stall[p] <= 1'b1;
            wr_wait[p]            <= 4'h0;
            wr_left[p]            <= 8'h00;
            wr_idx[p]             <= 32'h00000000;
         end else if (wr_take[p]) begin
            link.wr_port_stall[p] <= 1'b1;
            wr_wait[p]            <= 4'h0;
            wr_idx[p]             <= wr_cur[p] + 32'h00000001;
            if (wr_left[p] == 8'h00)
               wr_left[p] <= first_left(link.wr_port_beat_count[p]);
            else
               wr_left[p] <= wr_left[p] - 8'h01;
         end else if (link.wr_port_request[p]) begin
            if (wr_wait[p] >= WAIT4)
               link.wr_port_stall[p] <= 1'b0;
            else
               wr_wait[p] <= wr_wait[p] + 4'h1;
         end
      end
   end

   // Storage has no reset; contents are undefined until written
   always_ff @(posedge clock) begin : storage
      for (int p = 0; p < `MAX_PORTS; p++) begin
         if (rst_n && CFG_OK && p < NUM_WR && wr_take[p] && in_range(wr_cur[p]))
            mem[wr_cur[p]] <= link.wr_port_payload[p];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read ports

   always_ff @(posedge clock) begin : read_ctrl
      for (int p = 0; p < `MAX_PORTS; p++) begin
         if (!rst_n || p >= NUM_RD || !CFG_OK) begin
            link.rd_port_stall[p] <= 1'b1;
            rd_left[p]            <= 8'h00;
            rd_idx[p]             <= 32'h00000000;
         end else if (rd_take[p]) begin
            // hold off new reads during a burst
            link.rd_port_stall[p] <= link.rd_port_beat_count[p] > 8'h01;
            rd_left[p]            <= first_left(link.rd_port_beat_count[p]);
            rd_idx[p]             <= rd_cur[p] + 32'h00000001;
         end else if (rd_left[p] != 8'h00) begin
            link.rd_port_stall[p] <= rd_left[p] > 8'h01;
            rd_left[p]            <= rd_left[p] - 8'h01;
            rd_idx[p]             <= rd_cur[p] + 32'h00000001;
         end else begin
            link.rd_port_stall[p] <= 1'b0;
         end
      end
   end

   // Fixed-depth delay line; a full pipe lets every beat issue back to back
   always_ff @(posedge clock) begin : read_pipe
      for (int p = 0; p < `MAX_PORTS; p++) begin
         if (!rst_n || p >= NUM_RD || !CFG_OK) begin
            for (int s = 0; s < `MAX_LATENCY; s++) begin
               rd_ok_pipe[p][s]  <= 1'b0;
               rd_dat_pipe[p][s] <= '0;
            end
         end else begin
            rd_ok_pipe[p][0]  <= rd_issue[p];
            rd_dat_pipe[p][0] <= (rd_issue[p] && in_range(rd_cur[p])) ? mem[rd_cur[p]] : '0;
            for (int s = 1; s < `MAX_LATENCY; s++) begin
               rd_ok_pipe[p][s]  <= rd_ok_pipe[p][s-1];
               rd_dat_pipe[p][s] <= rd_dat_pipe[p][s-1];
            end
         end
      end
   end

   always_comb begin
      for (int p = 0; p < `MAX_PORTS; p++) begin
         link.rd_port_payload_ok[p] = rd_ok_pipe[p][LAT-1];
         link.rd_port_payload[p]    = rd_dat_pipe[p][LAT-1];
      end
   end

endmodule : mem_model

// >>> logic/mem_model_consts.svh
`ifndef MEM_MODEL_CONSTS_SVH
`define MEM_MODEL_CONSTS_SVH

// Carrier sizing: the link has room for the most ports; model data and address widths must equal these
`define MAX_PORTS      5
`define DATA_W         32
`define ADDR_W         16
`define BEAT_W         8

// Default model configuration
`define NUM_WR_PORTS   2
`define NUM_RD_PORTS   2
`define WAIT_STATES    2
`define READ_LATENCY   4
`define MEM_SIZE_BYTES 1024
`define MEM_OFFSET     256

// Legal configuration limits
`define MAX_WAIT       10
`define MAX_LATENCY    255
`define MAX_ADDR_W     32

`endif

// >>> logic/mem_types_pkg.sv
`include "mem_model_consts.svh"

package mem_types_pkg;

   typedef logic [`DATA_W-1:0] word_t;
   typedef logic [`ADDR_W-1:0] loc_t;
   typedef logic [`BEAT_W-1:0] beats_t;

   typedef enum logic [0:0] {
      WR_IDLE,
      WR_SEND
   } wr_phase_t;

   typedef enum logic [1:0] {
      RD_IDLE,
      RD_ASK,
      RD_WAIT
   } rd_phase_t;

endpackage : mem_types_pkg

// >>> logic/mem_link_if.sv
`timescale 1ns/1ns
`include "mem_model_consts.svh"

interface mem_link_if;
   import mem_types_pkg::*;

   word_t  wr_port_payload    [`MAX_PORTS];
   loc_t   wr_port_location   [`MAX_PORTS];
   logic   wr_port_request    [`MAX_PORTS];
   beats_t wr_port_beat_count [`MAX_PORTS];
   logic   wr_port_stall      [`MAX_PORTS];
   loc_t   rd_port_location   [`MAX_PORTS];
   logic   rd_port_request    [`MAX_PORTS];
   beats_t rd_port_beat_count [`MAX_PORTS];
   logic   rd_port_stall      [`MAX_PORTS];
   word_t  rd_port_payload    [`MAX_PORTS];
   logic   rd_port_payload_ok [`MAX_PORTS];

   modport model (
      input  wr_port_payload,
      input  wr_port_location,
      input  wr_port_request,
      input  wr_port_beat_count,
      output wr_port_stall,
      input  rd_port_location,
      input  rd_port_request,
      input  rd_port_beat_count,
      output rd_port_stall,
      output rd_port_payload,
      output rd_port_payload_ok
   );

   modport master (
      output wr_port_payload,
      output wr_port_location,
      output wr_port_request,
      output wr_port_beat_count,
      input  wr_port_stall,
      output rd_port_location,
      output rd_port_request,
      output rd_port_beat_count,
      input  rd_port_stall,
      input  rd_port_payload,
      input  rd_port_payload_ok
   );

endinterface : mem_link_if

// >>> logic/mem_master.sv
`timescale 1ns/1ns
`include "mem_model_consts.svh"

module mem_master #(
   parameter int WR_SEL = 0,
   parameter int RD_SEL = 0
) (
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   mem_link_if.master                 link,
   input  wire logic                  wr_go,
   input  wire mem_types_pkg::loc_t   wr_addr,
   input  wire mem_types_pkg::beats_t wr_beats,
   input  wire mem_types_pkg::word_t  wr_data,
   output logic                       wr_busy,
   output logic                       wr_beat,
   input  wire logic                  rd_go,
   input  wire mem_types_pkg::loc_t   rd_addr,
   input  wire mem_types_pkg::beats_t rd_beats,
   output logic                       rd_busy,
   output mem_types_pkg::word_t       rd_data,
   output logic                       rd_data_ok
);
   import mem_types_pkg::*;

   function automatic beats_t at_least_one(input beats_t count);
      return (count == 8'h00) ? 8'h01 : count;
   endfunction : at_least_one

   wr_phase_t wr_phase;
   rd_phase_t rd_phase;
   beats_t    wr_left;
   beats_t    rd_left;

   ////////////////////////////////////////////////////////////////////////
   // Write burst; a stalled beat keeps request, address and data still

   always_ff @(posedge clock) begin : write_side
      if (!rst_n) begin
         wr_phase <= WR_IDLE;
         wr_left  <= 8'h00;
         wr_busy  <= 1'b0;
         wr_beat  <= 1'b0;
         for (int p = 0; p < `MAX_PORTS; p++) begin
            link.wr_port_request[p]    <= 1'b0;
            link.wr_port_location[p]   <= '0;
            link.wr_port_beat_count[p] <= 8'h00;
            link.wr_port_payload[p]    <= '0;
         end
      end else begin
         wr_beat <= 1'b0;
         case (wr_phase)
            WR_IDLE: begin
               if (wr_go) begin
                  link.wr_port_request[WR_SEL]    <= 1'b1;
                  link.wr_port_location[WR_SEL]   <= wr_addr;
                  link.wr_port_payload[WR_SEL]    <= wr_data;
                  link.wr_port_beat_count[WR_SEL] <= at_least_one(wr_beats);
                  wr_left                         <= at_least_one(wr_beats);
                  wr_busy                         <= 1'b1;
                  wr_phase                        <= WR_SEND;
               end
            end
            WR_SEND: begin
               if (!link.wr_port_stall[WR_SEL]) begin
                  wr_beat <= 1'b1;
                  if (wr_left == 8'h01) begin
                     link.wr_port_request[WR_SEL] <= 1'b0;
                     wr_busy                      <= 1'b0;
                     wr_phase                     <= WR_IDLE;
                  end else begin
                     link.wr_port_payload[WR_SEL] <= wr_data;
                  end
                  wr_left <= wr_left - 8'h01;
               end
            end
            default: wr_phase <= WR_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read burst

   always_ff @(posedge clock) begin : read_side
      if (!rst_n) begin
         rd_phase <= RD_IDLE;
         rd_left  <= 8'h00;
         rd_busy  <= 1'b0;
         for (int p = 0; p < `MAX_PORTS; p++) begin
            link.rd_port_request[p]    <= 1'b0;
            link.rd_port_location[p]   <= '0;
            link.rd_port_beat_count[p] <= 8'h00;
         end
      end else begin
         if (link.rd_port_payload_ok[RD_SEL] && rd_left != 8'h00)
            rd_left <= rd_left - 8'h01;
         case (rd_phase)
            RD_IDLE: begin
               if (rd_go) begin
                  link.rd_port_request[RD_SEL]    <= 1'b1;
                  link.rd_port_location[RD_SEL]   <= rd_addr;
                  link.rd_port_beat_count[RD_SEL] <= at_least_one(rd_beats);
                  rd_left                         <= at_least_one(rd_beats);
                  rd_busy                         <= 1'b1;
                  rd_phase                        <= RD_ASK;
               end
            end
            RD_ASK: begin
               if (!link.rd_port_stall[RD_SEL]) begin
                  link.rd_port_request[RD_SEL] <= 1'b0;
                  rd_phase                     <= RD_WAIT;
               end
            end
            RD_WAIT: begin
               if (link.rd_port_payload_ok[RD_SEL] && rd_left == 8'h01) begin
                  rd_busy  <= 1'b0;
                  rd_phase <= RD_IDLE;
               end
            end
            default: rd_phase <= RD_IDLE;
         endcase
      end
   end

   // Returned words leave one cycle after the strobe, each flagged
   always_ff @(posedge clock) begin : read_return
      if (!rst_n) begin
         rd_data    <= '0;
         rd_data_ok <= 1'b0;
      end else begin
         rd_data_ok <= link.rd_port_payload_ok[RD_SEL] && rd_left != 8'h00;
         rd_data    <= link.rd_port_payload[RD_SEL];
      end
   end

endmodule : mem_master

// >>> tb/mem_link_monitor.sv
`timescale 1ns/1ns
`include "mem_model_consts.svh"

module mem_link_monitor (
   input wire logic                  clock,
   input wire logic                  rst_n,
   input wire logic                  wr_port_request    [`MAX_PORTS],
   input wire logic                  wr_port_stall      [`MAX_PORTS],
   input wire logic                  rd_port_request    [`MAX_PORTS],
   input wire mem_types_pkg::beats_t rd_port_beat_count [`MAX_PORTS],
   input wire logic                  rd_port_stall      [`MAX_PORTS],
   input wire logic                  rd_port_payload_ok [`MAX_PORTS]
);
   import mem_types_pkg::*;
   logic wr_take;
   logic rd_take;
   assign wr_take = wr_port_request[0] && !wr_port_stall[0];
   assign rd_take = rd_port_request[0] && !rd_port_stall[0];
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////
   // two wait states
   chk_wr_wait_count:
      assert property ($rose(wr_port_request[0]) |-> wr_port_stall[0] [*3] ##1 !wr_port_stall[0])
      else $error("write stall count wrong");
   chk_wr_beat_gap:
      assert property (wr_take |=> wr_port_stall[0] [*3])
      else $error("write beats too close");
   chk_wr_idle_stall:
      assert property (!wr_port_request[0] |=> wr_port_stall[0])
      else $error("write stall low while idle");
   chk_rd_latency:
      assert property (rd_take |-> ##4 rd_port_payload_ok[0])
      else $error("read word late");
   chk_rd_ok_cause:
      assert property ($rose(rd_port_payload_ok[0]) |-> $past(rd_take, 4))
      else $error("read strobe without request");
   chk_rd_burst_stall:
      assert property (rd_take && rd_port_beat_count[0] == 8'h04 |=> rd_port_stall[0] [*3] ##1 !rd_port_stall[0])
      else $error("read burst stall wrong");
   chk_rd_single_free:
      assert property (rd_take && rd_port_beat_count[0] <= 8'h01 |=> !rd_port_stall[0])
      else $error("read stall after single read");
   chk_rd_burst_words:
      assert property (rd_take && rd_port_beat_count[0] == 8'h04 |-> ##4 rd_port_payload_ok[0] [*4])
      else $error("read burst words missing");
   chk_spare_ports_stall:
      assert property (wr_port_stall[2] && rd_port_stall[2] && wr_port_stall[4] && rd_port_stall[4])
      else $error("spare port not stalled");
   cover property (wr_take);
   cover property (rd_take && rd_port_beat_count[0] == 8'h04);
   cover property ($rose(rd_port_payload_ok[0]));
endmodule : mem_link_monitor

// >>> tb/tb_mem_model.sv
`timescale 1ns/1ns
`include "mem_model_consts.svh"

module tb_mem_model;
   import mem_types_pkg::*;
   logic   clock;
   logic   rst_n;
   logic   wr_go;
   loc_t   wr_addr;
   beats_t wr_beats;
   word_t  wr_data;
   logic   wr_busy;
   logic   wr_beat;
   logic   rd_go;
   loc_t   rd_addr;
   beats_t rd_beats;
   logic   rd_busy;
   word_t  rd_data;
   logic   rd_data_ok;
   logic   cfg_fault;
   logic   bad_fault;
   int     fail_count;
   int     checks;
   int     spins;
   loc_t   edge_addr [3] = '{16'h04FC, 16'h0500, 16'h00FC};
   word_t  edge_want [3] = '{32'h1234_5678, 32'h0000_0000, 32'h0000_0000};

   mem_link_if link ();
   mem_link_if bad ();
   mem_link_if duo ();
   mem_model mem_model_inst (.clock(clock), .rst_n(rst_n), .link(link.model), .cfg_fault(cfg_fault));
   // Eleven wait states lie outside the legal set
   mem_model #(.WAIT_STATES(11)) mem_model_bad_inst (.clock(clock), .rst_n(rst_n), .link(bad.model),
      .cfg_fault(bad_fault));
   // Second legal model driven straight from here, so two ports can meet on one word
   mem_model mem_model_duo_inst (.clock(clock), .rst_n(rst_n), .link(duo.model), .cfg_fault());
   mem_master mem_master_inst (.clock(clock), .rst_n(rst_n), .link(link.master), .wr_go(wr_go),
      .wr_addr(wr_addr), .wr_beats(wr_beats), .wr_data(wr_data), .wr_busy(wr_busy), .wr_beat(wr_beat),
      .rd_go(rd_go), .rd_addr(rd_addr), .rd_beats(rd_beats), .rd_busy(rd_busy), .rd_data(rd_data),
      .rd_data_ok(rd_data_ok));
   mem_link_monitor mem_link_monitor_inst (.clock(clock), .rst_n(rst_n),
      .wr_port_request(link.wr_port_request), .wr_port_stall(link.wr_port_stall),
      .rd_port_request(link.rd_port_request), .rd_port_beat_count(link.rd_port_beat_count),
      .rd_port_stall(link.rd_port_stall), .rd_port_payload_ok(link.rd_port_payload_ok));

   ////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
      checks++;
      if (seen !== want) begin
         fail_count++;
         $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
      end
   endtask : check

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict

   task automatic timed_out;
      fail_count++;
      $display("unexpected at %0t: wait ran out", $time);
      give_verdict();
   endtask : timed_out

   // Next beat data must be in place before the following accept edge
   task automatic write_burst(input loc_t addr, input beats_t beats, input word_t base);
      int n;
      int k;
      n = (beats == 8'h00) ? 1 : int'(beats);
      k = 0;
      wr_addr <= addr;
      wr_beats <= beats;
      wr_data <= base;
      wr_go <= 1'b1;
      @(posedge clock);
      wr_go <= 1'b0;
      wr_data <= base + 1;
      for (int t = 0; t < 300; t++) begin
         @(posedge clock);
         if (wr_beat === 1'b1) begin
            k++;
            wr_data <= base + k + 1;
         end
         if (wr_busy === 1'b0) begin
            check(k, n, "write beats");
            return;
         end
      end
      timed_out();
   endtask : write_burst

   task automatic read_burst(input loc_t addr, input beats_t beats, input word_t base, input word_t inc);
      int n;
      int k;
      n = (beats == 8'h00) ? 1 : int'(beats);
      k = 0;
      rd_addr <= addr;
      rd_beats <= beats;
      rd_go <= 1'b1;
      @(posedge clock);
      rd_go <= 1'b0;
      for (int t = 0; t < 300; t++) begin
         @(posedge clock);
         if (rd_data_ok === 1'b1) begin
            check(rd_data, base + k * inc, "read word");
            k++;
         end
         if (rd_busy === 1'b0) begin
            check(k, n, "read words");
            return;
         end
      end
      timed_out();
   endtask : read_burst

   ////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   initial begin
      rst_n = 1'b0;
      wr_go = 1'b0;
      wr_addr = 16'h0000;
      wr_beats = 8'h00;
      wr_data = 32'h0000_0000;
      rd_go = 1'b0;
      rd_addr = 16'h0000;
      rd_beats = 8'h00;
      fail_count = 0;
      checks = 0;
      foreach (bad.wr_port_request[i]) begin
         bad.wr_port_request[i]    = 1'b0;
         bad.rd_port_request[i]    = 1'b0;
         bad.wr_port_payload[i]    = '0;
         bad.wr_port_location[i]   = '0;
         bad.wr_port_beat_count[i] = '0;
         bad.rd_port_location[i]   = '0;
         bad.rd_port_beat_count[i] = '0;
         duo.wr_port_request[i]    = 1'b0;
         duo.rd_port_request[i]    = 1'b0;
         duo.wr_port_payload[i]    = '0;
         duo.wr_port_location[i]   = '0;
         duo.wr_port_beat_count[i] = '0;
         duo.rd_port_location[i]   = '0;
         duo.rd_port_beat_count[i] = '0;
      end
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      repeat (2) @(posedge clock);
      check(cfg_fault, 1'b0, "legal set flagged");
      check(bad_fault, 1'b1, "illegal wait accepted");
      check(bad.wr_port_stall[0], 1'b1, "write stall on bad set");
      check(bad.rd_port_stall[0], 1'b1, "read stall on bad set");
      $display("test configuration done");
      write_burst(16'h0100, 8'h04, 32'hA5A5_0000);
      read_burst(16'h0100, 8'h04, 32'hA5A5_0000, 32'h0000_0001);
      $display("test burst done");
      // range edges, count zero as one
      for (int i = 0; i < 3; i++) begin
         write_burst(edge_addr[i], 8'h00, 32'h1234_5678);
         read_burst(edge_addr[i], 8'h01, edge_want[i], 32'h0000_0000);
      end
      $display("test range done");
      // two ports write one word at one edge
      for (int p = 0; p < 2; p++) begin
         duo.wr_port_location[p]   <= 16'h0200;
         duo.wr_port_beat_count[p] <= 8'h01;
         duo.wr_port_request[p]    <= 1'b1;
      end
      duo.wr_port_payload[0] <= 32'h1111_1111;
      duo.wr_port_payload[1] <= 32'h2222_2222;
      for (spins = 0; spins < 30 && duo.wr_port_stall[0] !== 1'b0; spins++) @(posedge clock);
      if (spins == 30) timed_out();
      check(duo.wr_port_stall[1], 1'b0, "second port wait");
      duo.wr_port_request[0]    <= 1'b0;
      duo.wr_port_request[1]    <= 1'b0;
      duo.rd_port_location[0]   <= 16'h0200;
      duo.rd_port_beat_count[0] <= 8'h01;
      duo.rd_port_request[0]    <= 1'b1;
      @(posedge clock);
      check(duo.wr_port_stall[0], 1'b1, "write stall after beat");
      check(duo.rd_port_stall[0], 1'b0, "idle read stall");
      duo.rd_port_request[0]    <= 1'b0;
      for (spins = 0; spins < 30 && duo.rd_port_payload_ok[0] !== 1'b1; spins++) @(posedge clock);
      if (spins == 30) timed_out();
      check(spins, `READ_LATENCY, "read latency");
      check(duo.rd_port_payload[0], 32'h2222_2222, "higher port kept");
      $display("test port order done");
      give_verdict();
   end
endmodule : tb_mem_model
